// ==== shared/pm_fence_pkg.sv ====
// shared constants and carrier types for the switch power-management block
package pm_fence_pkg;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int unsigned NUM_DS     = 2;
  localparam int unsigned NUM_BDV    = 8;
  localparam int unsigned BDV_IDX_W  = 3;
  localparam int unsigned TMO_W      = 16;
  localparam int unsigned DATA_W     = 32;

  // ****************************************************************
  // timing: one timer tick in ns, converted to core clock cycles
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned TICK_NS       = 1000;
  localparam int unsigned TICK_CYC      = (TICK_NS + CLK_PERIOD_NS - 1)
                                          / CLK_PERIOD_NS;
  localparam int unsigned TICK_CNT_W    = 8;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [DATA_W-1:0] BCAP_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] BDV_RST  = 32'h0000_0000;

  // ****************************************************************
  // device power states and fence states (one-hot)
  // ****************************************************************
  typedef enum logic [3:0] {
    PS_D0U  = 4'h1,
    PS_D0A  = 4'h2,
    PS_D3H  = 4'h4,
    PS_D3C  = 4'h8
  } pwr_state_e;

  typedef enum logic [3:0] {
    FN_IDLE = 4'h1,
    FN_COLL = 4'h2,
    FN_ACK  = 4'h4,
    FN_DONE = 4'h8
  } fence_state_e;

  // per downstream port link status from the link layer
  typedef struct packed {
    logic active;
    logic in_l0;
    logic in_l23;
  } ds_link_s;

  // budget data register access
  typedef struct packed {
    logic                 wr;
    logic [BDV_IDX_W-1:0] idx;
    logic [DATA_W-1:0]    data;
  } bdv_wr_s;

endpackage : pm_fence_pkg

// ==== verilog/pcie_switch_pm_fence_pme.sv ====
// power-management event, turn-off fence and budgeting registers
// How it works
// R1 - no event messages while in D3cold
// R2 - ports emit hot-plug events from D3hot
// R3 - resend event when service timer expires
// R4 - root puts devices in D3, broadcasts
// R5 - turn-off accepted in any power state
// R6 - forward turn-off to active downstream ports
// R7 - ack upstream after all acks, enter L2/L3
// R8 - upstream TLP abandons ack collection
// R9 - after ack queued, drop later TLPs
// R10 - TLP aimed at switch handled normally
// R11 - forward TLP, retrain L2/L3 link first
// R12 - abandon leaves downstream handshakes running
// R13 - ack time-out counts as ack, L2/L3
// R14 - D0 uninitialized resumes event messages
// R15 - capability header zero unless loaded
// R16 - software links capability pointer chain
// R17 - eight budget data value registers
// R18 - data writes only while unlock set
// R19 - D3hot port may take link to L1
// R20 - timers count in fixed core ticks
`timescale 1ns/1ps
module pcie_switch_pm_fence_pme
  import pm_fence_pkg::*;
(
  input  wire logic                 i_mclk,
  input  wire logic                 i_rst,
  input  wire logic [1:0]           i_sw_pmstate,
  input  wire logic [2*NUM_DS-1:0]  i_ds_pmstate,
  input  wire logic                 i_pwr_removed,
  input  wire logic [NUM_DS-1:0]    i_hp_event,
  input  wire logic [NUM_DS-1:0]    i_pm_event_status_bit,
  input  wire logic [TMO_W*NUM_DS-1:0] i_event_service_timeout_field,
  input  wire logic [TMO_W*NUM_DS-1:0] i_turnoff_ack_timeout_field,
  input  wire ds_link_s [NUM_DS-1:0] i_ds_link,
  input  wire logic                 i_us_turnoff,
  input  wire logic                 i_us_tlp,
  input  wire logic                 i_us_tlp_to_self,
  input  wire logic [NUM_DS-1:0]    i_us_tlp_port,
  input  wire logic [NUM_DS-1:0]    i_ds_ack,
  input  wire logic                 i_budget_data_unlock_bit,
  input  wire logic                 i_eeprom_load,
  input  wire logic [DATA_W-1:0]    i_eeprom_bcap,
  input  wire bdv_wr_s              i_bdv_wr,
  input  wire logic [BDV_IDX_W-1:0] i_bdv_rd_idx,
  output logic [NUM_DS-1:0]         o_pme_send,
  output logic [NUM_DS-1:0]         o_ds_turnoff,
  output logic                      o_us_ack,
  output logic                      o_us_to_l23,
  output logic                      o_abandoned,
  output logic                      o_tlp_drop,
  output logic                      o_tlp_local,
  output logic [NUM_DS-1:0]         o_tlp_fwd,
  output logic [NUM_DS-1:0]         o_ds_retrain,
  output logic [NUM_DS-1:0]         o_ds_to_l23,
  output logic [NUM_DS-1:0]         o_ds_ack_tmo,
  output logic [NUM_DS-1:0]         o_ds_l1_allow,
  output logic [DATA_W-1:0]         o_budget_capability_header,
  output logic [DATA_W-1:0]         o_bdv_rd_data,
  output logic [1:0]                o_pwr_state
);

  // ****************************************************************
  // device power state
  // ****************************************************************
  pwr_state_e ps_r;

  // pm state codes: 0 = D0, 3 = D3hot
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      ps_r <= PS_D0U;
    end else if (i_pwr_removed) begin
      ps_r <= PS_D3C;
    end else begin
      unique case (ps_r)
        PS_D0U: if (i_sw_pmstate == 2'h3) ps_r <= PS_D3H;
                else ps_r <= PS_D0A;
        PS_D0A: if (i_sw_pmstate == 2'h3) ps_r <= PS_D3H;
        PS_D3H: if (i_sw_pmstate == 2'h0) ps_r <= PS_D0U; // [R14]
        PS_D3C: ps_r <= PS_D3C;
      endcase
    end
  end

  always_comb begin
    unique case (ps_r)
      PS_D0U:  o_pwr_state = 2'h0;
      PS_D0A:  o_pwr_state = 2'h1;
      PS_D3H:  o_pwr_state = 2'h2;
      PS_D3C:  o_pwr_state = 2'h3;
      default: o_pwr_state = 2'h3;
    endcase
  end

  // ****************************************************************
  // shared tick for all timers
  // ****************************************************************
  logic [TICK_CNT_W-1:0] tick_cnt_r;
  logic                  tick;

  assign tick = (tick_cnt_r == TICK_CNT_W'(TICK_CYC - 1));

  always_ff @(posedge i_mclk) begin
    if (i_rst || tick) begin
      tick_cnt_r <= '0; // [R20]
    end else begin
      tick_cnt_r <= tick_cnt_r + 1'b1;
    end
  end

  // ****************************************************************
  // fence state machine
  // ****************************************************************
  fence_state_e         fn_r;
  logic [NUM_DS-1:0]    pend_r;
  logic [NUM_DS-1:0]    ack_tmo;
  logic                 collect_done;

  assign collect_done = (pend_r & ~i_ds_ack & ~ack_tmo) == '0;

  // a turnoff is taken in every power state, even D3cold housekeeping
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      fn_r <= FN_IDLE;
    end else begin
      unique case (fn_r)
        FN_IDLE: if (i_us_turnoff) fn_r <= FN_COLL; // [R5]
        FN_COLL: begin
          if (i_us_tlp) fn_r <= FN_IDLE; // [R8]
          else if (collect_done) fn_r <= FN_ACK; // [R7]
        end
        FN_ACK:  fn_r <= FN_DONE;
        FN_DONE: if (i_us_turnoff) fn_r <= FN_COLL;
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_us_ack    <= 1'b0;
      o_us_to_l23 <= 1'b0;
      o_abandoned <= 1'b0;
    end else begin
      o_us_ack    <= (fn_r == FN_COLL) && !i_us_tlp && collect_done; // [R7]
      o_us_to_l23 <= (fn_r == FN_ACK) ? 1'b1 :
                     (fn_r == FN_IDLE) ? 1'b0 : o_us_to_l23;
      o_abandoned <= (fn_r == FN_COLL) && i_us_tlp; // [R8]
    end
  end

  // ****************************************************************
  // upstream TLP routing
  // ****************************************************************
  logic tlp_live;

  assign tlp_live = i_us_tlp && (fn_r != FN_ACK) && (fn_r != FN_DONE);

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_tlp_drop  <= 1'b0;
      o_tlp_local <= 1'b0;
    end else begin
      o_tlp_drop  <= i_us_tlp &&
                     ((fn_r == FN_ACK) || (fn_r == FN_DONE)); // [R9]
      o_tlp_local <= tlp_live && i_us_tlp_to_self; // [R10]
    end
  end

  // ****************************************************************
  // per downstream port: events, turnoff, ack timer, forwarding
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < NUM_DS; g++) begin : g_ds
      logic [TMO_W-1:0] ev_tmr_r;
      logic             ev_wait_r;
      logic [TMO_W-1:0] ack_tmr_r;
      logic             hold_r;
      logic             ds_d3h;
      logic             ev_ok;
      logic             ev_expire;
      logic             want_tlp;

      assign ds_d3h = (i_ds_pmstate[2*g +: 2] == 2'h3);
      // cold switch stays silent; D3hot at port or switch may signal
      assign ev_ok = (ps_r != PS_D3C) &&
                     (ds_d3h || (ps_r == PS_D3H)); // [R1] [R2]
      assign ev_expire = ev_wait_r && tick &&
        (ev_tmr_r >= i_event_service_timeout_field[TMO_W*g +: TMO_W]);
      assign o_ds_l1_allow[g] = ds_d3h; // [R19]

      always_ff @(posedge i_mclk) begin
        if (i_rst) begin
          o_pme_send[g] <= 1'b0;
          ev_wait_r     <= 1'b0;
          ev_tmr_r      <= '0;
        end else begin
          o_pme_send[g] <= 1'b0;
          if (!i_pm_event_status_bit[g] || !ev_ok) begin
            ev_wait_r <= 1'b0; // [R1]
          end else if ((i_hp_event[g] && !ev_wait_r) || ev_expire) begin
            o_pme_send[g] <= 1'b1; // [R3]
            ev_wait_r     <= 1'b1;
            ev_tmr_r      <= '0;
          end else if (ev_wait_r && tick) begin
            ev_tmr_r <= ev_tmr_r + 1'b1; // [R20]
          end
        end
      end

      // pending survives an abandon so the handshake runs on
      assign ack_tmo[g] = pend_r[g] && tick &&
        (ack_tmr_r >= i_turnoff_ack_timeout_field[TMO_W*g +: TMO_W]);

      always_ff @(posedge i_mclk) begin
        if (i_rst) begin
          pend_r[g]       <= 1'b0;
          ack_tmr_r       <= '0;
          o_ds_turnoff[g] <= 1'b0;
          o_ds_ack_tmo[g] <= 1'b0;
        end else begin
          o_ds_turnoff[g] <= 1'b0;
          o_ds_ack_tmo[g] <= ack_tmo[g] && !i_ds_ack[g];
          if (i_us_turnoff && (fn_r != FN_COLL) && i_ds_link[g].active) begin
            o_ds_turnoff[g] <= 1'b1; // [R6]
            pend_r[g]       <= 1'b1;
            ack_tmr_r       <= '0;
          end else if (pend_r[g] && (i_ds_ack[g] || ack_tmo[g])) begin
            pend_r[g] <= 1'b0; // [R13] [R12]
          end else if (pend_r[g] && tick) begin
            ack_tmr_r <= ack_tmr_r + 1'b1;
          end
        end
      end

      always_ff @(posedge i_mclk) begin
        if (i_rst) begin
          o_ds_to_l23[g] <= 1'b0;
        end else if (pend_r[g] && (i_ds_ack[g] || ack_tmo[g])) begin
          o_ds_to_l23[g] <= 1'b1; // [R13]
        end else if (i_ds_link[g].in_l0) begin
          o_ds_to_l23[g] <= 1'b0;
        end
      end

      // a TLP for a sleeping link waits in hold_r until it retrains
      assign want_tlp = (tlp_live && !i_us_tlp_to_self &&
                         i_us_tlp_port[g]) || hold_r;

      always_ff @(posedge i_mclk) begin
        if (i_rst) begin
          hold_r          <= 1'b0;
          o_tlp_fwd[g]    <= 1'b0;
          o_ds_retrain[g] <= 1'b0;
        end else begin
          o_tlp_fwd[g]    <= want_tlp && i_ds_link[g].in_l0; // [R11]
          o_ds_retrain[g] <= want_tlp && !i_ds_link[g].in_l0 &&
                             !hold_r; // [R11]
          hold_r          <= want_tlp && !i_ds_link[g].in_l0;
        end
      end

      a_ack_done: assert property (@(posedge i_mclk) disable iff (i_rst)
        (pend_r[g] && i_ds_ack[g] && !i_us_turnoff) |=> !pend_r[g]) // [R13]
        else $error("port pending did not clear on ack");
      a_cold_quiet: assert property (@(posedge i_mclk) disable iff (i_rst)
        (ps_r == PS_D3C) |=> !o_pme_send[g]) // [R1]
        else $error("event message sent in D3cold");
      a_turnoff_fwd: assert property (@(posedge i_mclk) disable iff (i_rst)
        (i_us_turnoff && fn_r == FN_IDLE && i_ds_link[g].active)
        |=> o_ds_turnoff[g]) // [R6]
        else $error("turnoff not forwarded to active port");
      a_fwd_l0: assert property (@(posedge i_mclk) disable iff (i_rst)
        (tlp_live && !i_us_tlp_to_self && i_us_tlp_port[g] &&
         i_ds_link[g].in_l0) |=> o_tlp_fwd[g]) // [R11]
        else $error("TLP to L0 port not forwarded");
      a_tmo_l23: assert property (@(posedge i_mclk) disable iff (i_rst)
        ack_tmo[g] |=> o_ds_to_l23[g]) // [R13]
        else $error("timed-out port not moved to L2/L3");
    end
  endgenerate

  // ****************************************************************
  // power budgeting registers
  // ****************************************************************
  logic [DATA_W-1:0] bdv_r [NUM_BDV];

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_budget_capability_header <= BCAP_RST; // [R15]
    end else if (i_eeprom_load) begin
      o_budget_capability_header <= i_eeprom_bcap; // [R15]
    end
  end

  generate
    for (g = 0; g < NUM_BDV; g++) begin : g_bdv
      always_ff @(posedge i_mclk) begin
        if (i_rst) begin
          bdv_r[g] <= BDV_RST;
        end else if (i_bdv_wr.wr && i_budget_data_unlock_bit &&
                     i_bdv_wr.idx == BDV_IDX_W'(g)) begin
          bdv_r[g] <= i_bdv_wr.data; // [R17] [R18]
        end
      end
    end
  endgenerate

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_bdv_rd_data <= '0;
    end else begin
      o_bdv_rd_data <= bdv_r[i_bdv_rd_idx];
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  a_ack_after_all: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_us_ack |-> $past(collect_done) && !$past(i_us_tlp)) // [R7]
    else $error("upstream ack before all acks");
  a_abandon_idle: assert property (@(posedge i_mclk) disable iff (i_rst)
    (fn_r == FN_COLL && i_us_tlp) |=> (fn_r == FN_IDLE) && o_abandoned) // [R8]
    else $error("collection not abandoned on TLP");
  a_drop_after: assert property (@(posedge i_mclk) disable iff (i_rst)
    (fn_r == FN_DONE && i_us_tlp) |=> o_tlp_drop && !o_tlp_local) // [R9]
    else $error("TLP after ack not dropped");
  a_local_tlp: assert property (@(posedge i_mclk) disable iff (i_rst)
    (fn_r == FN_COLL && i_us_tlp && i_us_tlp_to_self) |=> o_tlp_local) // [R10]
    else $error("abandoning TLP for the switch not handled");
  a_l23_after: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_us_ack |=> o_us_to_l23) // [R7]
    else $error("upstream link not moved to L2/L3");
  a_locked_bdv: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_bdv_wr.wr && !i_budget_data_unlock_bit)
    |=> bdv_r[$past(i_bdv_wr.idx)] == $past(bdv_r[i_bdv_wr.idx])) // [R18]
    else $error("locked budget register changed");
  a_resume_d0u: assert property (@(posedge i_mclk) disable iff (i_rst)
    (ps_r == PS_D3H && i_sw_pmstate == 2'h0 && !i_pwr_removed)
    |=> ps_r == PS_D0U) // [R14]
    else $error("no return to D0 uninitialized");

endmodule : pcie_switch_pm_fence_pme

// ==== verif/pm_link_partner.sv ====
// downstream link partners answering turn-off and retrain requests
`timescale 1ns/1ps
module pm_link_partner
  import pm_fence_pkg::*;
(
  input  wire logic                   i_mclk,
  input  wire logic                   i_rst,
  input  wire logic [NUM_DS-1:0]      i_turnoff,
  input  wire logic [NUM_DS-1:0]      i_retrain,
  input  wire logic [NUM_DS-1:0]      i_to_l23,
  input  wire logic [NUM_DS-1:0]      i_ack_en,
  input  wire logic [NUM_DS-1:0][7:0] i_dly,
  output logic      [NUM_DS-1:0]      o_ack,
  output ds_link_s  [NUM_DS-1:0]      o_link
);
  // {active, in_l0, in_l23}
  localparam ds_link_s LNK_L0  = 3'h6;
  localparam ds_link_s LNK_L23 = 3'h5;
  int                cnt_r [NUM_DS];
  int                rt_r  [NUM_DS];
  logic [NUM_DS-1:0] l23_q;
  always @(posedge i_mclk) begin
    l23_q <= i_to_l23;
    for (int g = 0; g < NUM_DS; g++) begin
      o_ack[g] <= 1'b0;
      if (i_rst) begin
        cnt_r[g]  <= 0;
        rt_r[g]   <= 0;
        o_link[g] <= LNK_L0;
      end else begin
        // acks even after the switch gave up collecting
        if (i_turnoff[g] && i_ack_en[g]) begin
          cnt_r[g] <= i_dly[g];
        end else if (cnt_r[g] > 1) begin
          cnt_r[g] <= cnt_r[g] - 1;
        end else if (cnt_r[g] == 1) begin
          cnt_r[g]  <= 0;
          o_ack[g]  <= 1'b1;
          o_link[g] <= LNK_L23;
        end
        // detect then L0 a few cycles after a retrain request
        if (i_retrain[g]) begin
          rt_r[g] <= 5;
        end else if (rt_r[g] > 1) begin
          rt_r[g] <= rt_r[g] - 1;
        end else if (rt_r[g] == 1) begin
          rt_r[g]   <= 0;
          o_link[g] <= LNK_L0;
        end
        // a silent port is pushed to L2/L3 by the switch
        if (i_to_l23[g] && !l23_q[g]) begin
          o_link[g] <= LNK_L23;
        end
      end
    end
  end
endmodule : pm_link_partner

// ==== verif/test_pcie_switch_pm_fence_pme.sv ====
// self-checking bench for the power-management fence block
`timescale 1ns/1ps
module test_pcie_switch_pm_fence_pme;
  import pm_fence_pkg::*;
  logic i_mclk, i_rst, i_pwr_removed, i_us_turnoff, i_us_tlp;
  logic i_us_tlp_to_self, i_budget_data_unlock_bit, i_eeprom_load;
  logic [1:0] i_sw_pmstate, i_us_tlp_port, i_hp_event, i_pm_event_status_bit;
  logic [3:0] i_ds_pmstate;
  logic [31:0] ev_tmo, ack_tmo, i_eeprom_bcap, o_bcap, o_rd;
  logic [2:0] i_bdv_rd_idx;
  bdv_wr_s i_bdv_wr;
  ds_link_s [NUM_DS-1:0] ds_link;
  logic [1:0] ds_ack, ack_en, pme, ds_to, fwd, rt, tmo, to_l23, l1ok, pst;
  logic [NUM_DS-1:0][7:0] dly;
  logic us_ack, us_l23, ab, drop, loc;
  logic [1:0] h_pme, h_to, h_fwd, h_rt, h_tmo;
  logic h_ack, h_ab, h_drop, h_loc;
  int err_count, compares, cyc_n;
  // ****************************************************************
  // clock, design and far side
  // ****************************************************************
  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end
  pcie_switch_pm_fence_pme dut (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_sw_pmstate(i_sw_pmstate), .i_ds_pmstate(i_ds_pmstate),
    .i_pwr_removed(i_pwr_removed), .i_hp_event(i_hp_event),
    .i_pm_event_status_bit(i_pm_event_status_bit),
    .i_event_service_timeout_field(ev_tmo),
    .i_turnoff_ack_timeout_field(ack_tmo), .i_ds_link(ds_link),
    .i_us_turnoff(i_us_turnoff), .i_us_tlp(i_us_tlp),
    .i_us_tlp_to_self(i_us_tlp_to_self), .i_us_tlp_port(i_us_tlp_port),
    .i_ds_ack(ds_ack), .i_budget_data_unlock_bit(i_budget_data_unlock_bit),
    .i_eeprom_load(i_eeprom_load), .i_eeprom_bcap(i_eeprom_bcap),
    .i_bdv_wr(i_bdv_wr), .i_bdv_rd_idx(i_bdv_rd_idx), .o_pme_send(pme),
    .o_ds_turnoff(ds_to), .o_us_ack(us_ack), .o_us_to_l23(us_l23),
    .o_abandoned(ab), .o_tlp_drop(drop), .o_tlp_local(loc), .o_tlp_fwd(fwd),
    .o_ds_retrain(rt), .o_ds_to_l23(to_l23), .o_ds_ack_tmo(tmo),
    .o_ds_l1_allow(l1ok), .o_budget_capability_header(o_bcap),
    .o_bdv_rd_data(o_rd), .o_pwr_state(pst));
  pm_link_partner lp (.i_mclk(i_mclk), .i_rst(i_rst), .i_turnoff(ds_to),
    .i_retrain(rt), .i_to_l23(to_l23), .i_ack_en(ack_en), .i_dly(dly),
    .o_ack(ds_ack), .o_link(ds_link));
  // pulses are latched so a check never hinges on one exact edge
  always @(posedge i_mclk) begin
    h_pme  <= h_pme | pme;
    h_to   <= h_to | ds_to;
    h_fwd  <= h_fwd | fwd;
    h_rt   <= h_rt | rt;
    h_tmo  <= h_tmo | tmo;
    h_ack  <= h_ack | us_ack;
    h_ab   <= h_ab | ab;
    h_drop <= h_drop | drop;
    h_loc  <= h_loc | loc;
    cyc_n++;
    if (cyc_n == 10000) begin
      err_count++;
      final_report();
    end
  end
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge i_mclk);
  endtask : cyc
  task automatic clr();
    {h_pme, h_to, h_fwd, h_rt, h_tmo} = '0;
    {h_ack, h_ab, h_drop, h_loc} = '0;
  endtask : clr
  task automatic us(input logic to, tl, sf, input logic [1:0] pt);
    i_us_turnoff = to;
    i_us_tlp = tl;
    i_us_tlp_to_self = sf;
    i_us_tlp_port = pt;
    cyc(1);
    {i_us_turnoff, i_us_tlp, i_us_tlp_to_self, i_us_tlp_port} = '0;
  endtask : us
  task automatic ev(input logic [1:0] p);
    clr();
    i_hp_event = p;
    cyc(1);
    i_hp_event = '0;
    cyc(2);
  endtask : ev
  task automatic wr_rd(input logic [2:0] ix, input logic [31:0] d, e);
    i_bdv_wr = {1'b1, ix, d};
    cyc(1);
    i_bdv_wr.wr = 1'b0;
    i_bdv_rd_idx = ix;
    cyc(2);
    chk("bdv_rd_data", o_rd, e);
  endtask : wr_rd
  task automatic final_report();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report
  // ****************************************************************
  // sequence
  // ****************************************************************
  initial begin
    {i_rst, i_pwr_removed, i_us_turnoff, i_us_tlp, i_us_tlp_to_self} = 5'h10;
    {i_budget_data_unlock_bit, i_eeprom_load, i_eeprom_bcap} = '0;
    {i_sw_pmstate, i_ds_pmstate, i_us_tlp_port, i_hp_event} = '0;
    {i_pm_event_status_bit, i_bdv_rd_idx, i_bdv_wr} = '0;
    ev_tmo = 32'h0001_0001;
    ack_tmo = 32'h0010_0010;
    ack_en = 2'h3;
    dly = {8'h1E, 8'h02};
    {err_count, compares, cyc_n} = '0;
    clr();
    repeat (10) @(posedge i_mclk);
    cyc(1);
    i_rst = 1'b0;
    cyc(2);
    chk("pwr_state", pst, 32'h1);
    chk("bcap", o_bcap, 32'h0);
    wr_rd(3'h7, 32'hA5A5_0001, 32'h0);
    i_budget_data_unlock_bit = 1'b1;
    for (int k = 0; k < 8; k++) begin
      wr_rd(3'(k), 32'hB0D0_0000 + k, 32'hB0D0_0000 + k);
    end
    i_budget_data_unlock_bit = 1'b0;
    wr_rd(3'h0, 32'h0000_0001, 32'hB0D0_0000);
    i_eeprom_bcap = 32'h0001_000B; // next pointer left at zero
    i_eeprom_load = 1'b1;
    cyc(1);
    i_eeprom_load = 1'b0;
    cyc(2);
    chk("bcap", o_bcap, 32'h0001_000B);
    clr();
    us(0, 1, 0, 2'h1);
    cyc(2);
    chk("tlp_fwd", h_fwd, 32'h1);
    // turn-off while the switch sits in D3hot, port 1 acks late
    i_sw_pmstate = 2'h3;
    cyc(3);
    chk("pwr_state", pst, 32'h2);
    clr();
    us(1, 0, 0, 2'h0);
    cyc(2);
    chk("ds_turnoff", h_to, 32'h3);
    cyc(20);
    chk("us_ack", h_ack, 32'h0);
    cyc(20);
    chk("us_ack", h_ack, 32'h1);
    chk("us_to_l23", us_l23, 32'h1);
    clr();
    us(0, 1, 0, 2'h1);
    cyc(2);
    chk("tlp_drop", h_drop, 32'h1);
    chk("tlp_fwd", h_fwd, 32'h0);
    // abandon by a TLP for a port now in L2/L3
    clr();
    us(1, 0, 0, 2'h0);
    cyc(3);
    us(0, 1, 0, 2'h2);
    cyc(2);
    chk("abandoned", h_ab, 32'h1);
    chk("retrain", h_rt, 32'h2);
    cyc(12);
    chk("tlp_fwd", h_fwd, 32'h2);
    cyc(40);
    chk("us_ack", h_ack, 32'h0);
    clr();
    us(1, 0, 0, 2'h0);
    cyc(3);
    us(0, 1, 1, 2'h0);
    cyc(2);
    chk("abandoned", h_ab, 32'h1);
    chk("tlp_local", h_loc, 32'h1);
    cyc(40);
    // silent port 1 with a two-tick acknowledge limit
    ack_en = 2'h1;
    ack_tmo = 32'h0002_0002;
    clr();
    us(1, 0, 0, 2'h0);
    cyc(700);
    chk("ack_tmo", h_tmo, 32'h2);
    chk("us_ack", h_ack, 32'h1);
    chk("ds_to_l23", to_l23[1], 32'h1);
    ack_en = 2'h3;
    i_ds_pmstate = 4'hC;
    cyc(2);
    chk("l1_allow", l1ok, 32'h2);
    // hot-plug events: port in D3hot, then whole switch in D3hot
    i_sw_pmstate = 2'h0;
    i_ds_pmstate = 4'h3;
    i_pm_event_status_bit = 2'h1;
    cyc(1);
    chk("pwr_state", pst, 32'h0);
    cyc(2);
    ev(2'h1);
    chk("pme_send", h_pme, 32'h1);
    clr();
    cyc(450);
    chk("pme_send", h_pme, 32'h1);
    i_pm_event_status_bit = 2'h0;
    cyc(5);
    clr();
    cyc(450);
    chk("pme_send", h_pme, 32'h0);
    i_sw_pmstate = 2'h3;
    i_ds_pmstate = 4'h0;
    cyc(3);
    i_pm_event_status_bit = 2'h2;
    ev(2'h2);
    chk("pme_send", h_pme, 32'h2);
    i_pwr_removed = 1'b1;
    i_pm_event_status_bit = 2'h1;
    cyc(3);
    chk("pwr_state", pst, 32'h3);
    ev(2'h1);
    chk("pme_send", h_pme, 32'h0);
    // back to D0 uninitialized through reset, with power restored
    i_rst = 1'b1;
    i_pwr_removed = 1'b0;
    i_sw_pmstate = 2'h0;
    cyc(10);
    chk("pwr_state", pst, 32'h0);
    i_rst = 1'b0;
    i_ds_pmstate = 4'h3;
    cyc(3);
    ev(2'h1);
    chk("pme_send", h_pme[0], 32'h1);
    final_report();
  end
endmodule : test_pcie_switch_pm_fence_pme
